// ==== core/trw_ring_walker.sv ====
// ring walker: fetches descriptors, follows links, posts link events
// assumes memory answers on ref_clk after any delay and a downstream event ring writer
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`include "trw_ring_walker_regs.svh"
module trw_ring_walker (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   rdReq,
    output logic      [63:0]       rdAddr,
    input  wire logic              rdAck,
    input  wire trw_pkg::trw_ring_desc_t rdData,
    output logic                   cmdValid,
    input  wire logic              cmdReady,
    output logic                   xferValid,
    input  wire logic              xferReady,
    output logic                   xferInChain,
    output trw_pkg::trw_ring_desc_t execDesc,
    output logic      [63:0]       execPtr,
    output logic                   evValid,
    input  wire logic              evReady,
    output logic      [1:0]        evIdx,
    output logic      [31:0]       evData,
    output logic      [9:0]        evIntr
);
    import trw_pkg::*;

    trw_walk_st_t   state_q;
    trw_walk_st_t   state_d;
    trw_ring_ctx_t  ring_q [2];
    trw_ring_desc_t desc_q;
    logic        cur_q;
    logic [63:0] descAddr_q;
    logic [1:0]  pend_q;
    logic        chain_q;
    logic [2:0]  ctrl_q;
    logic [7:0]  slot_q;
    logic [4:0]  ep_q;
    logic [31:0] evCount_q;
    logic [127:0] evSh_q;
    logic [1:0]  evIdx_q;
    logic [9:0]  evIntr_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // bus decode
    wire       req     = wb_cyc_i & wb_stb_i;
    wire       wrEn    = req & wb_we_i & ack_q;
    wire       wrCtrl  = wrEn & (wb_adr_i == `TRW_OFF_CTRL);
    wire       wrDb    = wrEn & (wb_adr_i == `TRW_OFF_DOORBELL);
    wire       wrCmdLo = wrEn & (wb_adr_i == `TRW_OFF_CMD_LO);
    wire       wrCmdHi = wrEn & (wb_adr_i == `TRW_OFF_CMD_HI);
    wire       wrXfLo  = wrEn & (wb_adr_i == `TRW_OFF_XFER_LO);
    wire       wrXfHi  = wrEn & (wb_adr_i == `TRW_OFF_XFER_HI);
    wire       wrSlot  = wrEn & (wb_adr_i == `TRW_OFF_SLOT_EP);
    wire [1:0] dbSet   = wrDb ? (wb_dat_i[1:0] & {2{wb_sel_i[0]}}) : 2'b00;

    // capability bits: 0 interconnect latency support, 1 bandwidth, 2 latency
    wire ltmIc = ctrl_q[0];
    wire bwNegotiationCapable = ctrl_q[1];
    wire latencyMessagingCapable = ctrl_q[2];

    // descriptor decode
    wire        isDec   = (state_q == ST_DEC);
    wire        isDisp  = (state_q == ST_DISP);
    wire [5:0]  dType   = desc_q.ctl[`TRW_TYPE_MSB:`TRW_TYPE_LSB];
    wire        curCyc  = ring_q[cur_q].cyc;
    wire [63:0] curPtr  = ring_q[cur_q].ptr;
    wire        ownOk   = (desc_q.ctl[`TRW_BIT_CYCLE] == curCyc);
    wire        isLink  = (dType == `TRW_TYPE_LINK);
    wire        complFlag = desc_q.ctl[`TRW_BIT_COMPL];
    wire        toggle  = desc_q.ctl[`TRW_BIT_TOGGLE];
    wire        cmdRing = ~cur_q;
    wire        negBw   = (dType == `TRW_CMD_NEG_BW);
    wire        setLt   = (dType == `TRW_CMD_SET_LT);
    wire        unsupBw = negBw & ~bwNegotiationCapable;
    wire        unsupLt = setLt & ~(ltmIc | latencyMessagingCapable);
    wire        unsup   = cmdRing & ~isLink & (unsupBw | unsupLt);
    wire        linkTake = isDec & ownOk & isLink;
    wire        postEv  = isDec & ownOk & ((isLink & complFlag) | unsup);
    wire        dispRdy = cmdRing ? cmdReady : xferReady;
    wire        advance = (linkTake | (isDec & ownOk & unsup)) | (isDisp & dispRdy);
    wire        empty   = isDec & ~ownOk;
    // any 16-byte aligned target, always the first descriptor there
    wire [63:0] linkPtr = {desc_q.param[63:4], 4'h0};
    wire [63:0] nextPtr = linkTake ? linkPtr : curPtr + `TRW_DESC_BYTES;
    wire        nextCyc = curCyc ^ (linkTake & toggle);
    wire        lastEvW = (state_q == ST_EVENT) & evReady & (evIdx_q == 2'd3);

    // event words, dword 0 first and dword 3 with the cycle position last
    wire [7:0]   evCc   = unsup ? `TRW_CC_DESC_ERR : `TRW_CC_SUCCESS;
    wire [31:0]  xfDw3  = {slot_q, 3'b000, ep_q, `TRW_TYPE_XFER_EV, 10'h000};
    wire [31:0]  cmDw3  = {8'h00, 8'h00, `TRW_TYPE_CMD_EV, 10'h000};
    wire [31:0]  evDw2  = {evCc, 24'h000000};
    wire [31:0]  evDw3  = cmdRing ? cmDw3 : xfDw3;
    wire [127:0] evWord = {evDw3, evDw2, descAddr_q};
    // command completions to interrupter 0, target field of command links unused
    wire [9:0]   evTgt  = cmdRing ? 10'h000 : desc_q.status[31:22];

    // register read mux
    wire [31:0] statusW = {22'h000000, chain_q, pend_q, ring_q[1].cyc,
                           ring_q[0].cyc, state_q};
    logic [31:0] rdMux;
    always_comb begin
        unique case (wb_adr_i)
            `TRW_OFF_CTRL:     rdMux = {29'h00000000, ctrl_q};
            `TRW_OFF_CMD_LO:   rdMux = {ring_q[0].ptr[31:1], ring_q[0].cyc};
            `TRW_OFF_CMD_HI:   rdMux = ring_q[0].ptr[63:32];
            `TRW_OFF_XFER_LO:  rdMux = {ring_q[1].ptr[31:1], ring_q[1].cyc};
            `TRW_OFF_XFER_HI:  rdMux = ring_q[1].ptr[63:32];
            `TRW_OFF_SLOT_EP:  rdMux = {19'h00000, ep_q, slot_q};
            `TRW_OFF_STATUS:   rdMux = statusW;
            `TRW_OFF_CMD_DEQ:  rdMux = ring_q[0].ptr[31:0];
            `TRW_OFF_XFER_DEQ: rdMux = ring_q[1].ptr[31:0];
            `TRW_OFF_EVCOUNT:  rdMux = evCount_q;
            default:           rdMux = 32'h00000000;
        endcase
    end

    // walker sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (pend_q != 2'b00) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (rdAck) begin
                    state_d = ST_DEC;
                end
            end
            ST_DEC: begin
                if (postEv) begin
                    state_d = ST_EVENT;
                end else if (~ownOk | isLink) begin
                    state_d = ST_IDLE;
                end else begin
                    // force event, port bandwidth, force header, supported bandwidth and latency commands and transfers go to the executor
                    state_d = ST_DISP;
                end
            end
            ST_DISP: begin
                if (dispRdy) begin
                    state_d = ST_IDLE;
                end
            end
            ST_EVENT: begin
                if (lastEvW) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ring selection and fetch address, command ring first
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cur_q      <= 1'b0;
            descAddr_q <= 64'h0000000000000000;
        end else if (state_q == ST_IDLE && pend_q != 2'b00) begin
            cur_q      <= ~pend_q[0];
            descAddr_q <= pend_q[0] ? ring_q[0].ptr : ring_q[1].ptr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            desc_q <= '0;
        end else if (state_q == ST_FETCH && rdAck) begin
            desc_q <= rdData;
        end
    end

    // doorbell set wins over the empty-ring clear
    wire [1:0] pendClr = empty ? (cur_q ? 2'b10 : 2'b01) : 2'b00;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pend_q <= 2'b00;
        end else begin
            pend_q <= (pend_q & ~pendClr) | dbSet;
        end
    end

    // chain state survives links so a chained transfer continues past them
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chain_q <= 1'b0;
        end else if (isDisp & ~cmdRing & xferReady) begin
            chain_q <= desc_q.ctl[`TRW_BIT_CHAIN];
        end
    end

    // consumer pointer and cycle state; chain flag of links never consulted
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ring_q <= '{default: '0};
        end else begin
            if (advance) begin
                ring_q[cur_q].ptr <= nextPtr;
                ring_q[cur_q].cyc <= nextCyc;
            end
            if (wrCmdLo) begin
                ring_q[0].ptr[31:0] <= merge({ring_q[0].ptr[31:1], ring_q[0].cyc},
                                             wb_dat_i, wb_sel_i) & 32'hFFFFFFF0;
                ring_q[0].cyc <= wb_sel_i[0] ? wb_dat_i[0] : ring_q[0].cyc;
            end
            if (wrCmdHi) begin
                ring_q[0].ptr[63:32] <= merge(ring_q[0].ptr[63:32], wb_dat_i, wb_sel_i);
            end
            if (wrXfLo) begin
                ring_q[1].ptr[31:0] <= merge({ring_q[1].ptr[31:1], ring_q[1].cyc},
                                             wb_dat_i, wb_sel_i) & 32'hFFFFFFF0;
                ring_q[1].cyc <= wb_sel_i[0] ? wb_dat_i[0] : ring_q[1].cyc;
            end
            if (wrXfHi) begin
                ring_q[1].ptr[63:32] <= merge(ring_q[1].ptr[63:32], wb_dat_i, wb_sel_i);
            end
        end
    end

    // event shifter: dwords 0, 1, 2 then 3
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            evSh_q   <= '0;
            evIdx_q  <= 2'd0;
            evIntr_q <= 10'h000;
        end else if (postEv) begin
            evSh_q   <= evWord;
            evIdx_q  <= 2'd0;
            evIntr_q <= evTgt;
        end else if (state_q == ST_EVENT && evReady) begin
            evSh_q   <= {32'h00000000, evSh_q[127:32]};
            evIdx_q  <= evIdx_q + 2'd1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            evCount_q <= 32'h00000000;
        end else if (lastEvW) begin
            evCount_q <= evCount_q + 32'h00000001;
        end
    end

    // software configuration
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl_q <= `TRW_CTRL_RESET;
            slot_q <= 8'h00;
            ep_q   <= 5'h00;
        end else begin
            if (wrCtrl & wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[2:0];
            end
            if (wrSlot & wb_sel_i[0]) begin
                slot_q <= wb_dat_i[7:0];
            end
            if (wrSlot & wb_sel_i[1]) begin
                ep_q <= wb_dat_i[12:8];
            end
        end
    end

    // classic Wishbone: ack one cycle after the request, for one cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= (req & ~ack_q) ? rdMux : rdat_q;
        end
    end

    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = rdat_q;
    assign rdReq     = (state_q == ST_FETCH);
    assign rdAddr    = descAddr_q;
    assign cmdValid  = isDisp & cmdRing;
    assign xferValid = isDisp & ~cmdRing;
    assign xferInChain = chain_q;
    assign execDesc  = desc_q;
    assign execPtr   = descAddr_q;
    assign evValid   = (state_q == ST_EVENT);
    assign evIdx     = evIdx_q;
    assign evData    = evSh_q[31:0];
    assign evIntr    = evIntr_q;
endmodule : trw_ring_walker

// ==== shared/trw_ring_walker_regs.svh ====
// register offsets, descriptor field positions and encodings of the ring walker
// assumes byte addresses on a 32-bit classic Wishbone slave, one word per register
`ifndef TRW_RING_WALKER_REGS_SVH
`define TRW_RING_WALKER_REGS_SVH
`define TRW_OFF_CTRL     8'h00
`define TRW_OFF_DOORBELL 8'h04
`define TRW_OFF_CMD_LO   8'h08
`define TRW_OFF_CMD_HI   8'h0C
`define TRW_OFF_XFER_LO  8'h10
`define TRW_OFF_XFER_HI  8'h14
`define TRW_OFF_SLOT_EP  8'h18
`define TRW_OFF_STATUS   8'h1C
`define TRW_OFF_CMD_DEQ  8'h20
`define TRW_OFF_XFER_DEQ 8'h24
`define TRW_OFF_EVCOUNT  8'h28
`define TRW_CTRL_RESET   3'h0
`define TRW_BIT_CYCLE    0
`define TRW_BIT_TOGGLE   1
`define TRW_BIT_CHAIN    4
`define TRW_BIT_COMPL    5
`define TRW_TYPE_MSB     15
`define TRW_TYPE_LSB     10
`define TRW_TYPE_LINK    6'h06
`define TRW_TYPE_XFER_EV 6'h20
`define TRW_TYPE_CMD_EV  6'h21
`define TRW_CMD_FORCE_EV 6'h12
`define TRW_CMD_NEG_BW   6'h13
`define TRW_CMD_SET_LT   6'h14
`define TRW_CMD_PORT_BW  6'h15
`define TRW_CMD_FORCE_HD 6'h16
`define TRW_CC_SUCCESS   8'h01
`define TRW_CC_DESC_ERR  8'h05
`define TRW_DESC_BYTES   64'h10
`endif

// ==== shared/trw_pkg.sv ====
// types shared by the ring walker
// assumes nothing beyond a SystemVerilog compiler
package trw_pkg;
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] status;
        logic [63:0] param;
    } trw_ring_desc_t;

    typedef struct packed {
        logic [63:0] ptr;
        logic        cyc;
    } trw_ring_ctx_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_FETCH = 5'b00010,
        ST_DEC   = 5'b00100,
        ST_DISP  = 5'b01000,
        ST_EVENT = 5'b10000
    } trw_walk_st_t;
endpackage : trw_pkg

// ==== verification/trw_ring_walker_assertions.sv ====
// checker on the ring walker ports
// assumes a bind to trw_ring_walker, one clock, synchronous reset
module trw_ring_walker_assertions (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        rdReq,
    input wire logic [63:0] rdAddr,
    input wire logic        rdAck,
    input wire logic        cmdValid,
    input wire logic        xferValid,
    input wire logic        evValid,
    input wire logic        evReady,
    input wire logic [1:0]  evIdx,
    input wire logic [31:0] evData,
    input wire logic [9:0]  evIntr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack not a one-cycle pulse");
    property p_fetch; rdReq && !rdAck |=> rdReq && $stable(rdAddr); endproperty
    a_fetch: assert property (p_fetch) else $error("fetch dropped or moved");
    property p_align; rdReq |-> rdAddr[3:0] == 4'h0; endproperty
    a_align: assert property (p_align) else $error("fetch address unaligned");
    property p_one; $onehot0({rdReq, cmdValid, xferValid, evValid}); endproperty
    a_one: assert property (p_one) else $error("two operations at once");
    property p_evhold; evValid && !evReady |=> evValid && $stable({evIdx, evData}); endproperty
    a_evhold: assert property (p_evhold) else $error("event word changed");
    property p_evstep; evValid && evReady && evIdx != 2'h3 |=> evValid && evIdx == $past(evIdx) + 2'h1; endproperty
    a_evstep: assert property (p_evstep) else $error("event word order");
    property p_evfirst; $rose(evValid) |-> evIdx == 2'h0; endproperty
    a_evfirst: assert property (p_evfirst) else $error("event starts mid-way");
    property p_evlen; evValid && evIdx == 2'h2 |-> evData[23:0] == 24'h0; endproperty
    a_evlen: assert property (p_evlen) else $error("event length not zero");
    property p_cmdev; evValid && evIdx == 2'h3 && evData[15:10] == 6'h21 |-> evData[31:16] == 16'h0 && evIntr == 10'h0; endproperty
    a_cmdev: assert property (p_cmdev) else $error("command event ids");
    property p_evcyc; evValid && evIdx == 2'h3 |-> !evData[0]; endproperty
    a_evcyc: assert property (p_evcyc) else $error("event cycle bit set");
    c_cmd: cover property (evValid && evReady && evIdx == 2'h3 && evData[15:10] == 6'h21);
    c_xfer: cover property (evValid && evReady && evIdx == 2'h3 && evData[15:10] == 6'h20);
    c_slow: cover property (rdReq && !rdAck ##1 rdReq && !rdAck ##1 rdAck);
endmodule : trw_ring_walker_assertions
bind trw_ring_walker trw_ring_walker_assertions i_trw_ring_walker_assertions (
    .ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rdReq, .rdAddr, .rdAck,
    .cmdValid, .xferValid, .evValid, .evReady, .evIdx, .evData, .evIntr
);

// ==== verification/trw_mem_model.sv ====
// host memory holding the rings that software builds
// assumes rdReq held until rdAck, one fetch at a time
module trw_mem_model #(
    parameter int SLOW = 3
) (
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic           rdReq,
    input  wire logic [63:0]    rdAddr,
    output logic                rdAck,
    output trw_pkg::trw_ring_desc_t rdData
);
    timeunit 1ns;
    timeprecision 1ps;
    import trw_pkg::*;
    trw_ring_desc_t mem [logic [59:0]];  // whole 16-byte descriptors
    logic [3:0] waitQ;
    // odd slots answer late; data is scrambled outside the answer
    always_ff @(posedge ref_clk) begin
        rdAck <= 1'b0;
        rdData <= ~rdData;
        if (!nrst) begin
            waitQ <= 4'h0;
            rdData <= '0;
        end else if (rdReq && !rdAck) begin
            if (waitQ == (rdAddr[4] ? 4'(SLOW) : 4'h0)) begin
                rdAck <= 1'b1;
                rdData <= mem[rdAddr[63:4]];
                waitQ <= 4'h0;
            end else begin
                waitQ <= waitQ + 4'h1;
            end
        end
    end
endmodule : trw_mem_model

// ==== verification/trw_ring_walker_bench.sv ====
// bench for the ring walker: command ring, transfer ring, link events
// assumes the memory model serves fetches
module trw_ring_walker_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import trw_pkg::*;
    logic        ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rdReq, rdAck;
    logic        cmdValid, cmdReady, xferValid, xferReady, xferInChain, evValid, evReady;
    logic [3:0]  wb_sel_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, evData, rdat;
    logic [63:0] rdAddr, execPtr;
    logic [1:0]  evIdx;
    logic [9:0]  evIntr;
    logic [2:0]  vld;
    trw_ring_desc_t rdData, execDesc;
    int          errCount = 0;
    int          testsRun = 0;
    assign vld = {xferValid, cmdValid, evValid};
    trw_ring_walker i_trw_ring_walker (
        .ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .rdReq, .rdAddr, .rdAck, .rdData, .cmdValid, .cmdReady,
        .xferValid, .xferReady, .xferInChain, .execDesc, .execPtr, .evValid, .evReady,
        .evIdx, .evData, .evIntr
    );
    trw_mem_model #(.SLOW(3)) i_trw_mem_model (.ref_clk, .nrst, .rdReq, .rdAddr, .rdAck, .rdData);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : completeRun
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bound(input int n);
        if (n >= 300) begin
            errCount++;
            completeRun();
        end
    endtask : bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 300);
        bound(n);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic await(input int which);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (vld[which] !== 1'b1 && n < 300);
        bound(n);
    endtask : await
    task automatic put(input logic [63:0] a, input logic [5:0] t, input logic [9:0] f,
                       input logic [31:0] s, input logic [63:0] p);
        i_trw_mem_model.mem[a[63:4]] = '{ctl: {16'h0, t, f}, status: s, param: p};
    endtask : put
    task automatic takeEvent(input logic [63:0] p, input logic [31:0] w2,
                             input logic [31:0] w3, input logic [9:0] intr);
        logic [31:0] w [4];
        w = '{p[31:0], p[63:32], w2, w3};
        for (int i = 0; i < 4; i++) begin
            await(0);
            check("event word", {evIdx, evData}, {2'(i), w[i]});
            check("event target", evIntr, intr);
            evReady <= 1'b1;
            @(posedge ref_clk);
            evReady <= 1'b0;
        end
    endtask : takeEvent
    task automatic takeExec(input int which, input logic [63:0] p, input logic [5:0] t);
        await(which);
        check("exec address", execPtr, p);
        check("exec type", execDesc.ctl[15:10], t);
    endtask : takeExec
    task automatic give(input int which);
        cmdReady <= which == 1;
        xferReady <= which == 2;
        @(posedge ref_clk);
        cmdReady <= 1'b0;
        xferReady <= 1'b0;
    endtask : give
    initial begin
        logic [5:0]  typ [7];
        logic [31:0] cv [6];
        logic [63:0] seg;
        typ = '{6'h12, 6'h15, 6'h16, 6'h13, 6'h14, 6'h14, 6'h01};
        cv = '{32'h0, 32'h0, 32'h2, 32'h1, 32'h4, 32'h0};
        seg = 64'h0000_0002_0000_2080;
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {cmdReady, xferReady, evReady} = '0;
        wb_sel_i = 4'hF;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        wb(1'b0, 8'h00, 32'h0);
        check("control reset", rdat, 32'h0);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        wb(1'b0, 8'h40, 32'h0);
        check("unmapped read", rdat, 32'h0);
        put(64'h1040, 6'h13, 10'h001, 32'h0, 64'h0);  // aligned segment
        put(64'h1050, 6'h14, 10'h001, 32'h0, 64'h0);
        put(64'h1060, 6'h06, 10'h033, {10'h155, 22'h0}, seg);  // toggling link
        for (int k = 0; k < 7; k++) begin
            put(seg + 64'(k * 16), typ[k], {9'h0, k == 6}, 32'h0, 64'h0);
        end
        wb(1'b1, 8'h08, 32'h0000_1041);
        wb(1'b1, 8'h0C, 32'h0);
        wb(1'b1, 8'h04, 32'h1);
        takeEvent(64'h1040, 32'h0500_0000, 32'h0000_8400, 10'h0);
        takeEvent(64'h1050, 32'h0500_0000, 32'h0000_8400, 10'h0);
        takeEvent(64'h1060, 32'h0100_0000, 32'h0000_8400, 10'h0);
        check("chain ignored", xferInChain, 1'b0);
        for (int k = 0; k < 6; k++) begin
            takeExec(1, seg + 64'(k * 16), typ[k]);
            wb(1'b1, 8'h00, cv[k]);
            give(1);
        end
        wb(1'b1, 8'h18, 32'h0000_0503);
        put(64'h3000, 6'h01, 10'h011, 32'h0, 64'h0);  // chained across segments
        put(64'h3010, 6'h06, 10'h011, 32'h0, 64'h4000);
        put(64'h4000, 6'h01, 10'h001, 32'h0, 64'h0);
        put(64'h4010, 6'h06, 10'h023, {10'h007, 22'h0}, 64'h3000);
        wb(1'b1, 8'h10, 32'h0000_3001);
        wb(1'b1, 8'h14, 32'h0);
        wb(1'b1, 8'h04, 32'h2);
        takeExec(2, 64'h3000, 6'h01);
        give(2);
        takeExec(2, 64'h4000, 6'h01);
        check("chain carried", xferInChain, 1'b1);
        give(2);
        takeEvent(64'h4010, 32'h0100_0000, 32'h0305_8000, 10'h007);
        wb(1'b0, 8'h28, 32'h0);
        check("event count", rdat, 32'h4);
        wb(1'b0, 8'h24, 32'h0);
        check("transfer dequeue", rdat, 32'h3000);
        wb(1'b0, 8'h20, 32'h0);
        check("command dequeue", rdat, 32'h20E0);
        completeRun();
    end
endmodule : trw_ring_walker_bench
